// ---- sfs_pkg.sv ----
// sfs_pkg: constants and types for the sf supervision sequencer
// assumes a 125 MHz mclk; all timers tick on a 1 ms enable
`default_nettype none
package sfs_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W = 17;
  // nominal timing figures, milliseconds; break ratio in percent, counter width in bits
  localparam int unsigned T_AUG_MS = 400;
  localparam int unsigned T_HOLD_MS = 125;
  localparam int unsigned T_PRECUT_MS = 15;
  localparam int unsigned T_DIGIT_MS = 125;
  localparam int unsigned T_DISC_MS = 625;
  localparam int unsigned T_REMOVE_MS = 50;
  localparam int unsigned T_INSERT_MS = 13;
  localparam int unsigned T_BREAK_PCT = 58;
  localparam int unsigned T_PULSE_MS = 100;
  localparam int unsigned T_BREAK_MS = T_PULSE_MS * T_BREAK_PCT / 100;
  localparam int unsigned T_PULSE_END_MS = 200;
  localparam int unsigned MS_W = 10;
  // level encodings on tx_level, reset lead type, call state type
  localparam logic TX_LVL_NORMAL = 1'h0;
  localparam logic TX_LVL_AUG = 1'h1;
  localparam logic [1:0] EM_TYPE_RST = 2'h1;
  typedef enum logic [1:0] {SFS_IDLE, SFS_BUSY, SFS_DIAL} sfs_state_t;
endpackage
`default_nettype wire

// ---- sfs_sync.sv ----
// sfs_sync: two-flop synchroniser for one pin level
// assumes the input is asynchronous to mclk
`default_nettype none
module sfs_sync
  import sfs_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic sys_rst, // async reset
  input wire logic d, // raw pin
  output logic q // synchronised
);
  logic meta_q;
  logic meta_d;
  logic sync_d;
  always_comb begin
    meta_d = d;
    sync_d = meta_q;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'h0;
      q <= 1'h0;
    end else begin
      meta_q <= meta_d;
      q <= sync_d;
    end
  end
endmodule
`default_nettype wire

// ---- sfs_msdown.sv ----
// sfs_msdown: millisecond down-counter, loaded on start, done at zero
// assumes tick is a one-cycle 1 ms enable on mclk
`default_nettype none
module sfs_msdown
  import sfs_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic sys_rst, // async reset
  input wire logic srst, // sync clear
  input wire logic tick, // 1 ms enable
  input wire logic load, // start timing
  input wire logic [MS_W-1:0] len, // length in ms
  output logic run // counting
);
  logic [MS_W-1:0] cnt_q;
  logic [MS_W-1:0] cnt_d;
  logic run_d;
  always_comb begin
    cnt_d = cnt_q;
    run_d = run;
    if (srst) begin
      cnt_d = '0;
      run_d = 1'b0;
    end else if (load) begin
      cnt_d = len;
      run_d = 1'b1;
    end else if (run && tick) begin
      cnt_d = cnt_q - 1'b1;
      if (cnt_q <= MS_W'(1)) begin
        run_d = 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      run <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run <= run_d;
    end
  end
endmodule
`default_nettype wire

// ---- sfs_seq.sv ----
// sfs_seq: sf tone supervision sequencer, transmit cut and filter timing
// assumes leads and tone detect are async pins; levels are switch inputs
// Behaviour
// - idle tone sent at normal level
// - augmented level while pulsing and first interval
// - path cut idle, restored on busy
// - path cut while dialing locally
// - brief cut on input transition off-hook
// - seizure holds cut then releases
// - tone ceases: remove filter after delay
// - tone returns: insert filter after delay
// - local dialing precut, hold after last
// - local disconnect precut, long delay cut
// - loopback answers tone, augmented burst first
// - loopback pulses corrected to break ratio
// - three selectable lead interface types
// - side select swaps lead directions
// - a-side relay energised without rx tone
// - a-side tone while m lead idle
`default_nettype none
module sfs_seq
  import sfs_pkg::*;
(
  input wire logic mclk, // 125 MHz clock
  input wire logic sys_rst, // async reset, high
  input wire logic srst, // sync counter clear
  input wire logic side_b, // 1 = b-side
  input wire logic [1:0] em_type, // lead type 1..3
  input wire logic loopback, // signaling loopback on
  input wire logic in_lead_busy_pin, // incoming lead busy
  input wire logic rx_tone_pin, // rx tone detected
  output logic tx_tone_on, // send sf tone
  output logic tx_level, // 1 = augmented
  output logic tx_cut, // transmit path cut
  output logic receive_tone_reject_filter, // filter inserted
  output logic relay_energize, // output lead relay
  output logic e_is_output, // e lead is output
  output logic m_is_output, // m lead is output
  output logic [1:0] em_type_q // latched lead type
);
  // --------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------
  logic lead_s;
  logic tone_s;
  logic tone_ns;
  sfs_sync u_sync_lead (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d(in_lead_busy_pin),
    .q(lead_s)
  );
  // tone synced inverted: reset reads as idle tone present
  sfs_sync u_sync_tone (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d(!rx_tone_pin),
    .q(tone_ns)
  );

  // --------------------------------------------------------
  // 1 ms tick divider
  // --------------------------------------------------------
  logic [TICK_W-1:0] div_q;
  logic [TICK_W-1:0] div_d;
  logic tick_q;
  logic tick_d;
  always_comb begin
    div_d = div_q + 1'b1;
    tick_d = 1'b0;
    if (srst) begin
      div_d = '0;
    end else if (div_q == TICK_W'(TICK_CYC - 1)) begin
      div_d = '0;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // --------------------------------------------------------
  // edge history
  // --------------------------------------------------------
  logic lead_p_q;
  logic tone_p_q;
  logic lead_edge;
  logic tone_rise;
  logic tone_fall;
  logic lead_rise;
  logic lead_fall;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lead_p_q <= 1'b0;
      tone_p_q <= 1'b1;
    end else begin
      lead_p_q <= lead_s;
      tone_p_q <= tone_s;
    end
  end
  always_comb begin
    tone_s = ~tone_ns;
    lead_edge = lead_s ^ lead_p_q;
    lead_rise = lead_s & ~lead_p_q;
    lead_fall = ~lead_s & lead_p_q;
    tone_rise = tone_s & ~tone_p_q;
    tone_fall = ~tone_s & tone_p_q;
  end

  // --------------------------------------------------------
  // timers
  // --------------------------------------------------------
  logic aug_run;
  logic hold_run;
  logic pre_run;
  logic digit_run;
  logic disc_run;
  logic rem_run;
  logic ins_run;
  logic brk_run;
  logic tone_start;
  logic lb_tone;
  logic lb_fall;
  sfs_state_t st_q;
  sfs_state_t st_d;

  sfs_msdown u_aug (.mclk(mclk), .sys_rst(sys_rst), .srst(srst), .tick(tick_q),
    .load(tone_start), .len(MS_W'(T_AUG_MS)), .run(aug_run));
  // seizure hold, also hold after last transition
  sfs_msdown u_hold (.mclk(mclk), .sys_rst(sys_rst), .srst(srst), .tick(tick_q),
    .load(lead_edge), .len(MS_W'(T_HOLD_MS)), .run(hold_run));
  sfs_msdown u_pre (.mclk(mclk), .sys_rst(sys_rst), .srst(srst), .tick(tick_q),
    .load(lead_edge), .len(MS_W'(T_PRECUT_MS)), .run(pre_run));
  sfs_msdown u_digit (.mclk(mclk), .sys_rst(sys_rst), .srst(srst), .tick(tick_q),
    .load(lead_edge), .len(MS_W'(T_DIGIT_MS)), .run(digit_run));
  sfs_msdown u_disc (.mclk(mclk), .sys_rst(sys_rst), .srst(srst), .tick(tick_q),
    .load(lead_fall), .len(MS_W'(T_DISC_MS)), .run(disc_run));
  sfs_msdown u_rem (.mclk(mclk), .sys_rst(sys_rst), .srst(srst), .tick(tick_q),
    .load(tone_fall), .len(MS_W'(T_REMOVE_MS)), .run(rem_run));
  sfs_msdown u_ins (.mclk(mclk), .sys_rst(sys_rst), .srst(srst), .tick(tick_q),
    .load(tone_rise), .len(MS_W'(T_INSERT_MS)), .run(ins_run));
  sfs_msdown u_brk (.mclk(mclk), .sys_rst(sys_rst), .srst(srst), .tick(tick_q),
    .load(lb_fall), .len(MS_W'(T_BREAK_MS)), .run(brk_run));


  // --------------------------------------------------------
  // call state
  // --------------------------------------------------------
  // idle until incoming lead busy
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      SFS_IDLE: begin
        if (lead_s) begin
          st_d = SFS_BUSY;
        end
      end
      SFS_BUSY: begin
        if (lead_fall) begin
          st_d = SFS_DIAL;
        end
      end
      SFS_DIAL: begin
        if (lead_rise) begin
          st_d = SFS_BUSY;
        end else if (!disc_run && !lead_s) begin
          st_d = SFS_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= SFS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------
  // outputs
  // --------------------------------------------------------
  logic tone_d;
  logic level_d;
  logic cut_d;
  logic filt_d;
  logic relay_d;
  logic tone_on_q;
  logic rxt_q;
  logic rxt_d;
  always_comb begin
    // loopback echoes received tone; break widened to ratio
    lb_tone = tone_s & ~brk_run;
    lb_fall = loopback & tone_fall;
    tone_d = loopback ? lb_tone : !lead_s;
    tone_start = tone_d & ~tone_on_q;
    // normal idle level; augmented first interval or pulsing
    level_d = (aug_run || tone_start || (st_q == SFS_DIAL && digit_run)) ? TX_LVL_AUG : TX_LVL_NORMAL;
    // dialing cut; transition cut; long disconnect cut
    cut_d = (st_q == SFS_IDLE) || hold_run || pre_run || lead_edge ||
            (st_q == SFS_DIAL && !disc_run) || (rxt_q && !tone_s && rem_run);
    // removal after delay; insertion after delay
    filt_d = receive_tone_reject_filter;
    if (tone_s && !ins_run && !tone_rise) begin
      filt_d = 1'b1;
    end else if (!tone_s && !rem_run && !tone_fall) begin
      filt_d = 1'b0;
    end
    // a-side relay on with no tone; b-side opposite; side select
    relay_d = side_b ? tone_s : !tone_s;
    rxt_d = tone_s;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tone_on_q <= 1'b0;
      tx_tone_on <= 1'b0;
      tx_level <= TX_LVL_NORMAL;
      tx_cut <= 1'b1;
      receive_tone_reject_filter <= 1'b1;
      relay_energize <= 1'b0;
      rxt_q <= 1'b1;
      e_is_output <= 1'b1;
      m_is_output <= 1'b0;
      em_type_q <= EM_TYPE_RST;
    end else begin
      tone_on_q <= tone_d;
      tx_tone_on <= tone_d;
      tx_level <= level_d;
      tx_cut <= cut_d;
      receive_tone_reject_filter <= filt_d;
      relay_energize <= relay_d;
      rxt_q <= rxt_d;
      e_is_output <= !side_b;
      m_is_output <= side_b;
      if (em_type != 2'h0) begin
        em_type_q <= em_type;
      end
    end
  end

  // --------------------------------------------------------
  // checks
  // --------------------------------------------------------
  property p_idle_cut;
    @(posedge mclk) disable iff (sys_rst) (st_q == SFS_IDLE) |=> tx_cut;
  endproperty
  a_idle_cut: assert property (p_idle_cut) else $error("path not cut in idle");
  property p_edge_cut;
    @(posedge mclk) disable iff (sys_rst) lead_edge |=> tx_cut;
  endproperty
  a_edge_cut: assert property (p_edge_cut) else $error("no cut on lead edge");
  property p_aug_start;
    @(posedge mclk) disable iff (sys_rst) tone_start |=> tx_level == TX_LVL_AUG;
  endproperty
  a_aug_start: assert property (p_aug_start) else $error("tone start not augmented");
  property p_relay_a;
    @(posedge mclk) disable iff (sys_rst) (!side_b && !tone_s) |=> relay_energize;
  endproperty
  a_relay_a: assert property (p_relay_a) else $error("relay off without tone");
  property p_tone_m;
    @(posedge mclk) disable iff (sys_rst) (!loopback && lead_s) |=> !tx_tone_on;
  endproperty
  a_tone_m: assert property (p_tone_m) else $error("tone sent while busy");
  property p_ins_delay;
    @(posedge mclk) disable iff (sys_rst) (tone_rise && !receive_tone_reject_filter) |=> !receive_tone_reject_filter;
  endproperty
  a_ins_delay: assert property (p_ins_delay) else $error("filter inserted too soon");
  property p_rem_delay;
    @(posedge mclk) disable iff (sys_rst) (tone_fall && receive_tone_reject_filter) |=> receive_tone_reject_filter;
  endproperty
  a_rem_delay: assert property (p_rem_delay) else $error("filter removed too soon");
  property p_side;
    @(posedge mclk) disable iff (sys_rst) ##1 (e_is_output == !$past(side_b)) && (m_is_output == $past(side_b));
  endproperty
  a_side: assert property (p_side) else $error("lead direction wrong");
  property p_lb_break;
    @(posedge mclk) disable iff (sys_rst) (loopback && brk_run) |=> !tx_tone_on;
  endproperty
  a_lb_break: assert property (p_lb_break) else $error("loopback break not held");
  property p_dial_aug;
    @(posedge mclk) disable iff (sys_rst) (st_q == SFS_DIAL && digit_run) |=> tx_level == TX_LVL_AUG;
  endproperty
  a_dial_aug: assert property (p_dial_aug) else $error("dialing not augmented");
  property p_idle_normal;
    @(posedge mclk) disable iff (sys_rst) (st_q == SFS_IDLE && !aug_run && !tone_start) |=> tx_level == TX_LVL_NORMAL;
  endproperty
  a_idle_normal: assert property (p_idle_normal) else $error("idle level not normal");
endmodule
`default_nettype wire

// ---- sfs_far_model.sv ----
// sfs_far_model: stand-in for the terminal trunk and the distant tone repeater
// assumes the bench posts requests; pins move 1 ns after mclk rises
`default_nettype none
module sfs_far_model (
  input wire logic mclk, // clock
  input wire logic busy_req, // terminal lead busy wanted
  input wire logic tone_req, // distant tone wanted
  output logic in_lead_busy_pin, // incoming terminal lead
  output logic rx_tone_pin, // received tone present
  output logic rx_aug // tone at augmented level
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AUG_CYC = 400 * 125000;
  int aug_cnt;
  logic busy_v;
  logic tone_v;
  initial begin
    in_lead_busy_pin = 1'b0;
    rx_tone_pin = 1'b1;
    rx_aug = 1'b0;
    aug_cnt = 0;
  end
  always @(posedge mclk) begin
    // requests taken at the edge, before the bench moves them
    busy_v = busy_req;
    tone_v = tone_req;
    #1;
    in_lead_busy_pin = busy_v;
    if (tone_v && !rx_tone_pin) begin
      aug_cnt = AUG_CYC;
    end else if (aug_cnt > 0) begin
      aug_cnt = aug_cnt - 1;
    end
    rx_tone_pin = tone_v;
    rx_aug = tone_v && (aug_cnt > 0);
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// tb_top: self-checking bench for sfs_seq at its ports
// assumes the far side is sfs_far_model; ms timers too long to run out here
`default_nettype none
module tb_top;
  import sfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic side_b = 1'b0;
  logic busy_req = 1'b0;
  logic tone_req = 1'b1;
  logic [1:0] em_type = 2'h1;
  logic srst = 1'b0;
  logic loopback = 1'b0;
  logic in_lead_busy_pin, rx_tone_pin, rx_aug, tx_tone_on, tx_level, tx_cut, filt;
  logic relay_energize, e_is_output, m_is_output;
  logic [1:0] em_type_q;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  always #4 mclk = ~mclk;
  sfs_far_model far (.mclk(mclk), .busy_req(busy_req), .tone_req(tone_req),
    .in_lead_busy_pin(in_lead_busy_pin), .rx_tone_pin(rx_tone_pin), .rx_aug(rx_aug));
  sfs_seq DUT (.mclk(mclk), .sys_rst(sys_rst), .srst(srst), .side_b(side_b), .em_type(em_type),
    .loopback(loopback), .in_lead_busy_pin(in_lead_busy_pin), .rx_tone_pin(rx_tone_pin),
    .tx_tone_on(tx_tone_on), .tx_level(tx_level), .tx_cut(tx_cut), .receive_tone_reject_filter(filt),
    .relay_energize(relay_energize), .e_is_output(e_is_output), .m_is_output(m_is_output),
    .em_type_q(em_type_q));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // sync clear stands in for timers running out
  task automatic pulse_srst;
    srst = 1'b1;
    step(1);
    srst = 1'b0;
    step(3);
  endtask
  task automatic stop_test;
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_idle;
    step(6);
    check({11'h0, tx_tone_on}, 12'h1);
    check({11'h0, tx_cut}, 12'h1);
    check({11'h0, filt}, 12'h1);
    check({11'h0, relay_energize}, 12'h0);
  endtask
  task automatic t_rx_tone;
    tone_req = 1'b0;
    step(6);
    check({11'h0, relay_energize}, 12'h1);
    step(200);
    check({11'h0, filt}, 12'h1);
    pulse_srst();
    check({11'h0, filt}, 12'h0);
    check({11'h0, tx_level}, 12'h0);
    tone_req = 1'b1;
    step(6);
    check({11'h0, relay_energize}, 12'h0);
    check({11'h0, filt}, 12'h0);
    pulse_srst();
    check({11'h0, filt}, 12'h1);
  endtask
  task automatic t_seize;
    busy_req = 1'b1;
    step(6);
    check({11'h0, tx_tone_on}, 12'h0);
    check({11'h0, tx_cut}, 12'h1);
    step(1000);
    check({11'h0, tx_cut}, 12'h1);
    pulse_srst();
    check({11'h0, tx_cut}, 12'h0);
    busy_req = 1'b0;
    step(6);
    check({11'h0, tx_tone_on}, 12'h1);
    check({11'h0, tx_level}, 12'h1);
    check({11'h0, tx_cut}, 12'h1);
  endtask
  task automatic t_config;
    side_b = 1'b1;
    step(4);
    check({10'h0, e_is_output, m_is_output}, 12'h1);
    side_b = 1'b0;
    step(4);
    check({10'h0, e_is_output, m_is_output}, 12'h2);
    for (int t = 1; t <= 3; t++) begin
      em_type = t[1:0];
      step(4);
      check({10'h0, em_type_q}, {10'h0, t[1:0]});
    end
    em_type = 2'h0;
    step(4);
    check({10'h0, em_type_q}, 12'h3);
  endtask
  task automatic t_loop;
    loopback = 1'b1;
    tone_req = 1'b0;
    step(6);
    check({11'h0, tx_tone_on}, 12'h0);
    tone_req = 1'b1;
    step(6);
    check({11'h0, tx_tone_on}, 12'h0);
    pulse_srst();
    check({10'h0, tx_tone_on, tx_level}, 12'h3);
    loopback = 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    check({4'h0, tx_tone_on, tx_level, tx_cut, filt, relay_energize, e_is_output, m_is_output, 1'b0},
      12'h034);
    check({10'h0, em_type_q}, {10'h0, EM_TYPE_RST});
    sys_rst = 1'b0;
    t_idle();
    t_rx_tone();
    t_seize();
    t_config();
    t_loop();
    stop_test();
  end
endmodule
`default_nettype wire
